// file: rtl/osc_clock_ctrl.sv
// Behaviour
// - Trim is signed six bits, resets zero
// - Oscillator trim moves gradually, no status
// - Trim never touches low-frequency oscillator
// - Low clock: HF/512 or LF direct
// - PLL enable: soft bit at 8 MHz, or config pin
// - Primary drive bit powers drive, resets one
// - Lock and stable flags follow oscillators
// - Low-speed USB: 12 MHz with divider or 6 MHz without
// - Full-speed USB: 48 direct or 12x4
// - USB frequencies only when select is 00
`timescale 1ns/1ps
module osc_clock_ctrl
	import osc_clock_pkg::*;
#(
	parameter int SLEW_CYCLES = TUNE_STEP_CYCLES,
	parameter int SYNC_W      = 4
)
(
	input  wire logic        core_clk,
	input  wire logic        resetn,
	input  wire logic [2:0]  addr,
	input  wire logic [7:0]  wdata,
	input  wire logic        wr_stb,
	input  wire logic        rd_stb,
	output logic [7:0]       rdata,
	input  wire logic        hf_osc_locked,
	input  wire logic        lf_osc_stable,
	input  wire logic        hf_osc_clk,
	input  wire logic        lf_osc_clk,
	input  wire logic        hf_at_8mhz,
	input  wire logic        pll_config_on,
	output logic signed [5:0] hf_trim,
	output logic             pll_enable,
	output logic             primary_drive_on,
	output logic             low_freq_clk,
	output logic [1:0]       system_clock_select,
	output logic [1:0]       cpu_clock_divide,
	output logic [17:0]      sysclk_khz,
	output logic             usb_clock_ok
);

	osc_tuning_t          tuning_reg;
	clock_config_t        config_reg;
	logic [SYNC_W-1:0]    sync1_reg;
	logic [SYNC_W-1:0]    sync2_reg;
	logic                 hf_clk_prev_reg;
	logic [8:0]           div_cnt_reg;
	logic                 div_clk_reg;
	logic [17:0]          in_khz;
	logic [17:0]          base_khz;
	logic [17:0]          sysclk_next;
	logic                 usb_ok_next;
	logic [7:0]           rdata_next;
	logic                 hf_lock_flag;
	logic                 lf_stable_flag;
	logic                 hf_edge;
	logic                 pll_next;

	// Oscillator pins are asynchronous to the core clock
	// Two-flop synchronisers for the oscillator pin inputs only
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end
		else
		begin
			sync1_reg <= {lf_osc_clk, hf_osc_clk, lf_osc_stable, hf_osc_locked};
			sync2_reg <= sync1_reg;
		end
	end

	assign hf_lock_flag   = sync2_reg[0];
	assign lf_stable_flag = sync2_reg[1];

	// Register writes
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			tuning_reg <= RST_OSC_TUNING;
		end
		else if (wr_stb && addr == ADDR_OSC_TUNING)
		begin
			tuning_reg <= wdata;
		end
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			config_reg <= RST_CLOCK_CONFIG;
		end
		else if (wr_stb && addr == ADDR_CLOCK_CONFIG)
		begin
			config_reg <= wdata;
		end
	end

	// drive circuit control
	// Flags and upper bits of this register ignore writes
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			primary_drive_on <= RST_PRIMARY_DRIVE_ON;
		else if (wr_stb && addr == ADDR_OSC_STATUS_CONTROL_TWO)
			primary_drive_on <= wdata[POS_PRIMARY_DRIVE_ON];
	end

	tune_slew #(
		.STEP_CYCLES (SLEW_CYCLES)
	) u_slew (
		.core_clk (core_clk),
		.resetn   (resetn),
		.target   (tuning_reg.tune_field),
		.applied  (hf_trim)
	);

	// PLL gate
	// Fuse-enabled PLL runs regardless of the software bit
	// Unregistered gate also feeds the rate, so figures agree
	assign pll_next = (tuning_reg.pll_soft_enable && hf_at_8mhz) || pll_config_on;

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			pll_enable <= 1'b0;
		else
			pll_enable <= pll_next;
	end

	// trim only reaches the high-frequency path
	// Pin clock stays well below half the core clock rate
	assign hf_edge = sync2_reg[2] && !hf_clk_prev_reg;

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			hf_clk_prev_reg <= 1'b0;
		else
			hf_clk_prev_reg <= sync2_reg[2];
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			div_cnt_reg <= '0;
			div_clk_reg <= 1'b0;
		end
		else if (hf_edge)
		begin
			if (div_cnt_reg == 9'(LF_DIVIDE / 2 - 1))
			begin
				div_cnt_reg <= '0;
				div_clk_reg <= !div_clk_reg;
			end
			else
			begin
				div_cnt_reg <= div_cnt_reg + 1'b1;
			end
		end
	end

	// Divider runs always so a source switch is immediate
	// low clock source mux
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			low_freq_clk <= 1'b0;
		else if (tuning_reg.low_freq_source_select)
			low_freq_clk <= div_clk_reg;
		else
			low_freq_clk <= sync2_reg[3];
	end

	// Code 3 names no input and reads as 0 kHz
	// Input frequency decode
	always_comb
	begin
		in_khz = '0;
		if (config_reg.in_freq_sel == IN_FREQ_6MHZ)
			in_khz = KHZ_6MHZ;
		else if (config_reg.in_freq_sel == IN_FREQ_12MHZ)
			in_khz = KHZ_12MHZ;
		else if (config_reg.in_freq_sel == IN_FREQ_48MHZ)
			in_khz = KHZ_48MHZ;
	end

	// Even 48 MHz times four still fits in 18 bits
	// times four with PLL
	assign base_khz = pll_next ? 18'(in_khz << 2) : in_khz;

	// USB figures only with select 00
	// Other sources reported coarsely: low source or internal 16 MHz
	always_comb
	begin
		sysclk_next = '0;
		if (config_reg.system_clock_select == SYS_SEL_PRIMARY)
		begin
			case (config_reg.cpu_clock_divide)
				2'h0: sysclk_next = base_khz;
				2'h1: sysclk_next = base_khz >> 1;
				2'h2: sysclk_next = base_khz / 18'h00003;
				default: sysclk_next = base_khz >> 2;
			endcase
		end
		else if (config_reg.system_clock_select == SYS_SEL_LOW)
			sysclk_next = KHZ_LOW;
		else
			sysclk_next = KHZ_16MHZ;
	end

	always_comb
	begin
		usb_ok_next = 1'b0;
		if (config_reg.system_clock_select == SYS_SEL_PRIMARY)
		begin
			if (config_reg.full_speed)
				usb_ok_next = (config_reg.in_freq_sel == IN_FREQ_48MHZ && !pll_next)
					|| (config_reg.in_freq_sel == IN_FREQ_12MHZ && pll_next);
			else if (config_reg.in_freq_sel == IN_FREQ_12MHZ)
				usb_ok_next = config_reg.usb_clock_divide;
			else if (config_reg.in_freq_sel == IN_FREQ_6MHZ)
				usb_ok_next = !config_reg.usb_clock_divide;
		end
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			sysclk_khz   <= '0;
			usb_clock_ok <= 1'b0;
		end
		else
		begin
			sysclk_khz   <= sysclk_next;
			usb_clock_ok <= usb_ok_next;
		end
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			system_clock_select <= '0;
			cpu_clock_divide    <= '0;
		end
		else
		begin
			system_clock_select <= config_reg.system_clock_select;
			cpu_clock_divide    <= config_reg.cpu_clock_divide;
		end
	end

	// Flags come from the synchronisers, never the raw pins
	// Read mux; unmapped addresses read zero
	always_comb
	begin
		rdata_next = 8'h00;
		if (addr == ADDR_OSC_STATUS_CONTROL_TWO)
		begin
			rdata_next[POS_PRIMARY_DRIVE_ON] = primary_drive_on;
			rdata_next[POS_HF_LOCK_FLAG]     = hf_lock_flag;
			rdata_next[POS_LF_STABLE_FLAG]   = lf_stable_flag;
		end
		else if (addr == ADDR_OSC_TUNING)
			rdata_next = tuning_reg;
		else if (addr == ADDR_CLOCK_CONFIG)
			rdata_next = config_reg;
		else if (addr == ADDR_CLOCK_STATUS)
			rdata_next = {6'h00, pll_enable, usb_clock_ok};
		else if (addr == ADDR_SYSCLK_KHZ_LOW)
			rdata_next = sysclk_khz[7:0];
		else if (addr == ADDR_SYSCLK_KHZ_MID)
			rdata_next = sysclk_khz[15:8];
		else if (addr == ADDR_SYSCLK_KHZ_HIGH)
			rdata_next = {6'h00, sysclk_khz[17:16]};
	end

	// Data valid only the cycle after the strobe
	// Zero between reads keeps stale data off the bus
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			rdata <= 8'h00;
		else if (rd_stb)
			rdata <= rdata_next;
		else
			rdata <= 8'h00;
	end

endmodule

// file: rtl/osc_clock_pkg.sv
package osc_clock_pkg;

	// Register indices on the 3-bit core register port
	localparam logic [2:0] ADDR_OSC_STATUS_CONTROL_TWO = 3'h0;
	localparam logic [2:0] ADDR_OSC_TUNING             = 3'h1;
	localparam logic [2:0] ADDR_CLOCK_CONFIG           = 3'h2;
	localparam logic [2:0] ADDR_CLOCK_STATUS           = 3'h3;
	localparam logic [2:0] ADDR_SYSCLK_KHZ_LOW         = 3'h4;
	localparam logic [2:0] ADDR_SYSCLK_KHZ_MID         = 3'h5;
	localparam logic [2:0] ADDR_SYSCLK_KHZ_HIGH        = 3'h6;

	// osc_status_control_two field positions
	localparam int POS_PRIMARY_DRIVE_ON = 2;
	localparam int POS_HF_LOCK_FLAG     = 1;
	localparam int POS_LF_STABLE_FLAG   = 0;

	// Reset values
	localparam logic       RST_PRIMARY_DRIVE_ON = 1'b1;
	localparam logic [7:0] RST_OSC_TUNING       = 8'h00;
	localparam logic [7:0] RST_CLOCK_CONFIG     = 8'h00;

	// System clock source select codes
	localparam logic [1:0] SYS_SEL_PRIMARY = 2'h0;
	localparam logic [1:0] SYS_SEL_LOW     = 2'h1;

	// Input clock frequency codes of the clock configuration register
	localparam logic [1:0] IN_FREQ_6MHZ  = 2'h0;
	localparam logic [1:0] IN_FREQ_12MHZ = 2'h1;
	localparam logic [1:0] IN_FREQ_48MHZ = 2'h2;

	// Frequencies in kHz
	localparam logic [17:0] KHZ_6MHZ   = 18'h01770;
	localparam logic [17:0] KHZ_12MHZ  = 18'h02EE0;
	localparam logic [17:0] KHZ_48MHZ  = 18'h0BB80;
	localparam logic [17:0] KHZ_16MHZ  = 18'h03E80;
	localparam logic [17:0] KHZ_LOW    = 18'h0001F;

	// Low-frequency divider from the high-frequency oscillator
	localparam int LF_DIVIDE = 512;

	// Trim slew: one code step per interval
	localparam int TUNE_STEP_NS = 1000;
	localparam int CLK_PERIOD_NS = 10;
	localparam int TUNE_STEP_CYCLES = TUNE_STEP_NS / CLK_PERIOD_NS;

	typedef struct packed {
		logic       low_freq_source_select;
		logic       pll_soft_enable;
		logic [5:0] tune_field;
	} osc_tuning_t;

	typedef struct packed {
		logic       full_speed;
		logic [1:0] in_freq_sel;
		logic [1:0] system_clock_select;
		logic       usb_clock_divide;
		logic [1:0] cpu_clock_divide;
	} clock_config_t;

endpackage

// file: rtl/tune_slew.sv
`timescale 1ns/1ps
module tune_slew
	import osc_clock_pkg::*;
#(
	parameter int STEP_CYCLES = TUNE_STEP_CYCLES
)
(
	input  wire logic             core_clk,
	input  wire logic             resetn,
	input  wire logic signed [5:0] target,
	output logic signed [5:0]      applied
);

	localparam int CW = $clog2(STEP_CYCLES + 1);

	logic [CW-1:0] step_cnt_reg;

	// Interval timer
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			step_cnt_reg <= '0;
		else if (applied == target || step_cnt_reg == CW'(STEP_CYCLES - 1))
			step_cnt_reg <= '0;
		else
			step_cnt_reg <= step_cnt_reg + 1'b1;
	end

	// gradual approach
	// One code per interval so the oscillator never jumps
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			applied <= '0;
		else if (step_cnt_reg == CW'(STEP_CYCLES - 1))
		begin
			if (applied < target)
				applied <= applied + 6'sd1;
			else if (applied > target)
				applied <= applied - 6'sd1;
		end
	end

endmodule

// file: tb/osc_clock_ctrl_asserts.sv
`timescale 1ns/1ps
module osc_clock_ctrl_asserts
	import osc_clock_pkg::*;
(
	input wire logic [2:0]        addr,
	input wire logic              core_clk,
	input wire logic              resetn,
	input wire logic [7:0]        wdata,
	input wire logic              wr_stb,
	input wire logic              rd_stb,
	input wire logic [7:0]        rdata,
	input wire logic              hf_at_8mhz,
	input wire logic              pll_config_on,
	input wire logic signed [5:0] hf_trim,
	input wire logic              pll_enable,
	input wire logic              primary_drive_on,
	input wire logic [1:0]        system_clock_select,
	input wire logic [17:0]       sysclk_khz,
	input wire logic              usb_clock_ok
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	property p_trim_step;
		$changed(hf_trim) |-> 6'(hf_trim - $past(hf_trim)) inside {6'h01, 6'h3F};
	endproperty
	a_trim_step: assert property (p_trim_step) else $error("trim jumped");
	property p_trim_slew;
		wr_stb && addr == ADDR_OSC_TUNING && wdata[5:0] != hf_trim |=> ##[0:300] $changed(hf_trim);
	endproperty
	a_trim_slew: assert property (p_trim_slew) else $error("trim idle");
	property p_pll_cfg;
		pll_config_on |=> pll_enable;
	endproperty
	a_pll_cfg: assert property (p_pll_cfg) else $error("pll not on");
	property p_pll_off;
		!hf_at_8mhz && !pll_config_on |=> !pll_enable;
	endproperty
	a_pll_off: assert property (p_pll_off) else $error("pll not gated");
	property p_drive;
		wr_stb && addr == ADDR_OSC_STATUS_CONTROL_TWO |=> primary_drive_on == $past(wdata[2]);
	endproperty
	a_drive: assert property (p_drive) else $error("drive bit wrong");
	property p_status;
		rd_stb && addr == ADDR_OSC_STATUS_CONTROL_TWO |=> rdata[7:2] == {5'h00, primary_drive_on};
	endproperty
	a_status: assert property (p_status) else $error("status read wrong");
	property p_usb_sel;
		system_clock_select != SYS_SEL_PRIMARY |-> !usb_clock_ok;
	endproperty
	a_usb_sel: assert property (p_usb_sel) else $error("usb ok off primary");
	property p_low_khz;
		system_clock_select == SYS_SEL_LOW |-> sysclk_khz == KHZ_LOW;
	endproperty
	a_low_khz: assert property (p_low_khz) else $error("low clock rate");
endmodule
bind osc_clock_ctrl osc_clock_ctrl_asserts u_chk (.addr(addr), .core_clk(core_clk),
	.resetn(resetn), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
	.hf_at_8mhz(hf_at_8mhz), .pll_config_on(pll_config_on), .hf_trim(hf_trim),
	.pll_enable(pll_enable), .primary_drive_on(primary_drive_on),
	.system_clock_select(system_clock_select), .sysclk_khz(sysclk_khz),
	.usb_clock_ok(usb_clock_ok));

// file: tb/osc_clock_ctrl_tb.sv
`timescale 1ns/1ps
module osc_clock_ctrl_tb;
	import osc_clock_pkg::*;
	logic              core_clk = 1'b0;
	logic              resetn = 1'b0;
	logic [2:0]        addr = 3'h0;
	logic [7:0]        wdata = 8'h00;
	logic              wr_stb = 1'b0;
	logic              rd_stb = 1'b0;
	logic              hf_osc_locked = 1'b0;
	logic              lf_osc_stable = 1'b0;
	logic              hf_osc_clk = 1'b0;
	logic              lf_osc_clk = 1'b0;
	logic              hf_at_8mhz = 1'b0;
	logic              pll_config_on = 1'b0;
	logic [7:0]        rdata;
	logic signed [5:0] hf_trim;
	logic              pll_enable;
	logic              primary_drive_on;
	logic              low_freq_clk;
	logic              usb_clock_ok;
	logic [1:0]        system_clock_select;
	logic [1:0]        cpu_clock_divide;
	logic [17:0]       sysclk_khz;
	int                mismatches = 0;
	int                compares = 0;
	int                cycles = 0;
	int                n = 0;
	int                n0 = 0;
	localparam logic [7:0]  CFG [11] = '{8'h24, 8'h26, 8'h27, 8'h01, 8'h03, 8'h20, 8'hC2,
		8'hA3, 8'hAB, 8'hB3, 8'hC0};
	localparam logic        PLL [11] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1,
		1'b1, 1'b1, 1'b1};
	localparam logic [17:0] KHZ [11] = '{18'h0BB80, 18'h03E80, 18'h00BB8, 18'h02EE0,
		18'h005DC, 18'h02EE0, 18'h03E80, 18'h02EE0, 18'h0001F, 18'h03E80, 18'h2EE00};
	localparam logic        OK [11] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1,
		1'b0, 1'b0, 1'b0};

	osc_clock_ctrl #(.SLEW_CYCLES(3)) dut (.core_clk(core_clk), .resetn(resetn), .addr(addr),
		.wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
		.hf_osc_locked(hf_osc_locked), .lf_osc_stable(lf_osc_stable), .hf_osc_clk(hf_osc_clk),
		.lf_osc_clk(lf_osc_clk), .hf_at_8mhz(hf_at_8mhz), .pll_config_on(pll_config_on),
		.hf_trim(hf_trim), .pll_enable(pll_enable), .primary_drive_on(primary_drive_on),
		.low_freq_clk(low_freq_clk), .system_clock_select(system_clock_select),
		.cpu_clock_divide(cpu_clock_divide), .sysclk_khz(sysclk_khz),
		.usb_clock_ok(usb_clock_ok));

	initial
		forever #5 core_clk = ~core_clk;
	// Unrelated to core clock, near 16 MHz
	initial
		forever #31 hf_osc_clk = ~hf_osc_clk;
	always @(low_freq_clk)
		n++;
	always @(posedge core_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			mismatches++;
			conclude();
		end
	end

	task automatic conclude();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] got);
		compares++;
		if (got !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	// Gap cycle after each strobe keeps one assignment per step
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge core_clk);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge core_clk);
		wr_stb <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge core_clk);
		rd_stb <= 1'b0;
		#1 chk("rdata", {10'h000, exp}, {10'h000, rdata});
	endtask

	initial
	begin
		lf_osc_clk <= 1'b1;
		repeat (2) @(posedge core_clk);
		resetn <= 1'b1;
		rd(ADDR_OSC_STATUS_CONTROL_TWO, 8'h04); // drive reset
		rd(ADDR_OSC_TUNING, RST_OSC_TUNING); // trim zero
		rd(ADDR_CLOCK_STATUS, 8'h01); // usb ok
		rd(ADDR_SYSCLK_KHZ_LOW, 8'h70); // six MHz
		rd(ADDR_SYSCLK_KHZ_MID, 8'h17); // six MHz
		rd(3'h7, 8'h00); // unmapped zero
		$display("test reset done");
		hf_osc_locked <= 1'b1;
		lf_osc_stable <= 1'b1;
		repeat (4) @(posedge core_clk);
		rd(ADDR_OSC_STATUS_CONTROL_TWO, 8'h07); // flags set
		wr(ADDR_OSC_STATUS_CONTROL_TWO, 8'hF8); // upper ignored
		hf_osc_locked <= 1'b0;
		repeat (4) @(posedge core_clk);
		rd(ADDR_OSC_STATUS_CONTROL_TWO, 8'h01); // lock dropped
		chk("drive", 18'h0, {17'h0, primary_drive_on}); // drive off
		wr(ADDR_OSC_STATUS_CONTROL_TWO, 8'h04); // drive on
		$display("test status done");
		wr(ADDR_OSC_TUNING, 8'h1F); // max code
		#1 chk("trim jump", 18'h0, {17'h0, hf_trim == 6'sd31}); // gradual
		repeat (200) @(posedge core_clk);
		#1 chk("trim", 18'h1F, {12'h0, hf_trim}); // max trim
		n0 = n;
		wr(ADDR_OSC_TUNING, 8'h20); // min code
		repeat (300) @(posedge core_clk);
		#1 chk("trim", 18'h20, {12'h0, hf_trim}); // min trim
		chk("lf edges", 18'h0, 18'(n - n0)); // lf untouched
		chk("lf clk", 18'h1, {17'h0, low_freq_clk}); // direct source
		$display("test trim done");
		wr(ADDR_OSC_TUNING, 8'h80); // divided source
		repeat (8) @(posedge core_clk);
		n0 = n;
		repeat (4000) @(posedge core_clk);
		chk("div 512", 18'h1, {17'h0, (n - n0) inside {2, 3}}); // divide rate
		$display("test low clock done");
		wr(ADDR_OSC_TUNING, 8'h40); // soft enable
		rd(ADDR_CLOCK_STATUS, 8'h01); // gated off
		hf_at_8mhz <= 1'b1;
		rd(ADDR_CLOCK_STATUS, 8'h03); // pll on
		hf_at_8mhz <= 1'b0;
		$display("test pll done");
		foreach (CFG[i])
		begin
			pll_config_on <= PLL[i];
			wr(ADDR_CLOCK_CONFIG, CFG[i]); // usb setup
			@(posedge core_clk);
			#1 chk("khz", KHZ[i], sysclk_khz); // system rate
			chk("usb ok", {17'h0, OK[i]}, {17'h0, usb_clock_ok}); // usb legal
			chk("sel div", {14'h0, CFG[i][4:3], CFG[i][1:0]},
				{14'h0, system_clock_select, cpu_clock_divide}); // select out
		end
		rd(ADDR_SYSCLK_KHZ_HIGH, 8'h02); // rate high byte
		rd(ADDR_CLOCK_CONFIG, 8'hC0); // config readback
		$display("test usb done");
		resetn <= 1'b0;
		repeat (2) @(posedge core_clk);
		resetn <= 1'b1;
		rd(ADDR_OSC_TUNING, 8'h00); // reset zero
		chk("drive", 18'h1, {17'h0, primary_drive_on}); // reset one
		$display("test second reset done");
		conclude();
	end
endmodule
